// [hw/dac_volume_power_short_ctrl.sv]
// Volume, mute, power sequencing, driver mode and short-circuit control of a stereo DAC.
// Assumes host control bits are static levels synchronous to clk_sys_in.
`timescale 1ns/100ps
// Behaviour
// - Attenuation 0 to -63.5 dB in 0.5 dB codes.
// - Independent left and right mute.
// - Master volume sets both channels together.
// - Applied volume steps one code per sample toward target.
// - Half-rate bit steps once every two samples.
// - Done flags per channel when applied equals target.
// - Soft-step disable bypasses ramping.
// - Filter change: soft-mute, apply change, soft-unmute.
// - Power-up ramps from mute; power-down ramps to mute then off.
// - Power status 00 up, 01 powering up, 10 powering down, 11 down.
// - Drivers low-power after reset.
// - Driver power bit selects high-power mode.
// - Effects filter active only when enabled.
// - Two-bit swing field, 11 largest.
// - Lower mode bit set disables protection entirely.
// - Current-limit mode limits and flags excess current.
// - Flag follows the short in current-limit mode.
// - Upper mode bit: auto-shutdown drivers and set flag.
// - After shutdown, flag clears once DAC, mixer, keyclick all off.
module dac_volume_power_short_ctrl (
    input  wire logic                       clk_sys_in,
    input  wire logic                       arst_n_in,
    input  wire logic                       sample_valid_in,
    output logic                            sample_ready_out,
    input  wire dac_ctrl_pkg::sample_pair_s sample_in,
    output logic                            out_valid_out,
    input  wire logic                       out_ready_in,
    output dac_ctrl_pkg::sample_pair_s      out_sample_out,
    input  wire logic [6:0]                 vol_left_in,
    input  wire logic [6:0]                 vol_right_in,
    input  wire logic [6:0]                 vol_master_in,
    input  wire logic                       master_sel_in,
    input  wire logic                       mute_left_in,
    input  wire logic                       mute_right_in,
    input  wire logic                       half_rate_in,
    input  wire logic                       softstep_dis_in,
    input  wire logic                       deemph_en_in,
    input  wire logic                       effects_en_in,
    input  wire logic                       dac_power_in,
    input  wire logic                       mixer_power_in,
    input  wire logic                       keyclick_power_in,
    input  wire logic                       drv_high_power_in,
    input  wire logic [1:0]                 swing_in,
    input  wire logic [1:0]                 short_mode_in,
    input  wire logic                       short_detect_in,
    output logic [6:0]                      vol_left_out,
    output logic [6:0]                      vol_right_out,
    output logic                            done_left_out,
    output logic                            done_right_out,
    output logic [1:0]                      power_status_out,
    output logic                            deemph_active_out,
    output logic                            effects_active_out,
    output logic                            drv_high_power_out,
    output logic                            drv_enable_out,
    output logic                            current_limit_out,
    output logic [1:0]                      swing_out,
    output logic                            short_flag_out
);
    dac_ctrl_pkg::pwr_state_e   state_reg;
    dac_ctrl_pkg::pwr_state_e   state_next;
    dac_ctrl_pkg::sample_pair_s buf_data;
    logic       buf_valid;
    logic       sample_tick;
    logic       force_mute;
    logic       filt_change;
    logic [6:0] base_left;
    logic [6:0] base_right;
    logic [6:0] tgt_left;
    logic [6:0] tgt_right;
    logic [6:0] app_left;
    logic [6:0] app_right;
    logic       dn_left;
    logic       dn_right;
    logic       both_muted;
    logic       both_done;
    logic       deemph_reg;
    logic       effects_reg;
    logic       shutdown_reg;
    logic       short_flag_reg;
    logic       short_flag_next;
    logic       prot_off;
    logic       auto_mode;
    logic       limit_mode;
    logic       all_sources_off;
    logic [1:0] status_next;

    // Samples flow only when the output side accepts them, so stalls push back upstream.
    skid_buf2 u_buf (
        .clk_sys_in    (clk_sys_in),
        .arst_n_in     (arst_n_in),
        .in_valid_in   (sample_valid_in),
        .in_ready_out  (sample_ready_out),
        .in_data_in    (sample_in),
        .out_valid_out (buf_valid),
        .out_ready_in  (out_ready_in),
        .out_data_out  (buf_data)
    );
    assign sample_tick = buf_valid & out_ready_in;

    function automatic logic [6:0] chan_target(input logic [6:0] base, input logic mute,
                                               input logic fmute);
        chan_target = (mute | fmute) ? dac_ctrl_pkg::VOL_MUTE : base;
    endfunction : chan_target

    assign base_left  = master_sel_in ? vol_master_in : vol_left_in;
    assign base_right = master_sel_in ? vol_master_in : vol_right_in;
    assign tgt_left   = chan_target(base_left, mute_left_in, force_mute);
    assign tgt_right  = chan_target(base_right, mute_right_in, force_mute);

    vol_stepper u_left (
        .clk_sys_in     (clk_sys_in),
        .arst_n_in      (arst_n_in),
        .sample_tick_in (sample_tick),
        .half_rate_in   (half_rate_in),
        .bypass_in      (softstep_dis_in),
        .target_in      (tgt_left),
        .applied_out    (app_left),
        .done_out       (dn_left)
    );
    vol_stepper u_right (
        .clk_sys_in     (clk_sys_in),
        .arst_n_in      (arst_n_in),
        .sample_tick_in (sample_tick),
        .half_rate_in   (half_rate_in),
        .bypass_in      (softstep_dis_in),
        .target_in      (tgt_right),
        .applied_out    (app_right),
        .done_out       (dn_right)
    );

    assign both_muted  = (app_left == dac_ctrl_pkg::VOL_MUTE) &
                         (app_right == dac_ctrl_pkg::VOL_MUTE);
    assign both_done   = dn_left & dn_right;
    assign filt_change = (deemph_en_in != deemph_reg) | (effects_en_in != effects_reg);

    // Mute is forced everywhere except while running and settling into run.
    assign force_mute = (state_reg == dac_ctrl_pkg::ST_OFF) |
                        (state_reg == dac_ctrl_pkg::ST_FMUTE) |
                        (state_reg == dac_ctrl_pkg::ST_RAMP_DN);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            dac_ctrl_pkg::ST_OFF: begin
                if (dac_power_in) state_next = dac_ctrl_pkg::ST_RAMP_UP;
            end
            dac_ctrl_pkg::ST_RAMP_UP: begin
                if (!dac_power_in) state_next = dac_ctrl_pkg::ST_RAMP_DN;
                else if (filt_change) state_next = dac_ctrl_pkg::ST_FMUTE;
                else if (both_done) state_next = dac_ctrl_pkg::ST_RUN;
            end
            dac_ctrl_pkg::ST_RUN: begin
                if (!dac_power_in) state_next = dac_ctrl_pkg::ST_RAMP_DN;
                else if (filt_change) state_next = dac_ctrl_pkg::ST_FMUTE;
            end
            dac_ctrl_pkg::ST_FMUTE: begin
                if (!dac_power_in) state_next = dac_ctrl_pkg::ST_RAMP_DN;
                else if (both_muted) state_next = dac_ctrl_pkg::ST_RAMP_UP;
            end
            dac_ctrl_pkg::ST_RAMP_DN: begin
                if (both_muted) state_next = dac_ctrl_pkg::ST_OFF;
            end
            default: state_next = dac_ctrl_pkg::ST_OFF;
        endcase
    end

    // Status: up-stable in run, powering up while ramping up or filter-muting.
    assign status_next =
        (state_next == dac_ctrl_pkg::ST_OFF)     ? dac_ctrl_pkg::PWR_DOWN_STABLE :
        (state_next == dac_ctrl_pkg::ST_RAMP_DN) ? dac_ctrl_pkg::PWR_DOWNING :
        (state_next == dac_ctrl_pkg::ST_RUN)     ? dac_ctrl_pkg::PWR_UP_STABLE :
                                                   dac_ctrl_pkg::PWR_UPPING;

    // Short-circuit mode decode; protection-off has priority over auto-shutdown.
    assign prot_off   = short_mode_in[0];
    assign auto_mode  = ~prot_off & short_mode_in[1];
    assign limit_mode = ~prot_off & ~short_mode_in[1];
    assign all_sources_off = ~dac_power_in & ~mixer_power_in & ~keyclick_power_in;

    // Host clears a shutdown by removing all driver sources; the detector clears a limit flag.
    assign short_flag_next = prot_off ? 1'b0 :
                             short_detect_in ? 1'b1 :
                             (shutdown_reg & auto_mode & ~all_sources_off);

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_reg <= dac_ctrl_pkg::ST_OFF;
            power_status_out <= dac_ctrl_pkg::PWR_DOWN_STABLE;
        end else begin
            state_reg <= state_next;
            power_status_out <= status_next;
        end
    end

    // Filter settings latch only once the channels are muted, so the switch is silent.
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            deemph_reg  <= 1'b0;
            effects_reg <= 1'b0;
        end else if ((state_reg == dac_ctrl_pkg::ST_OFF) || both_muted) begin
            deemph_reg  <= deemph_en_in;
            effects_reg <= effects_en_in;
        end
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            shutdown_reg   <= 1'b0;
            short_flag_reg <= 1'b0;
        end else begin
            short_flag_reg <= short_flag_next;
            if (!auto_mode || all_sources_off) shutdown_reg <= 1'b0;
            if (auto_mode && short_detect_in) shutdown_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            vol_left_out       <= dac_ctrl_pkg::VOL_MUTE;
            vol_right_out      <= dac_ctrl_pkg::VOL_MUTE;
            done_left_out      <= 1'b1;
            done_right_out     <= 1'b1;
            deemph_active_out  <= 1'b0;
            effects_active_out <= 1'b0;
            drv_high_power_out <= 1'b0;
            drv_enable_out     <= 1'b0;
            current_limit_out  <= 1'b0;
            swing_out          <= dac_ctrl_pkg::SWING_RESET;
            short_flag_out     <= 1'b0;
        end else begin
            vol_left_out       <= app_left;
            vol_right_out      <= app_right;
            done_left_out      <= dn_left;
            done_right_out     <= dn_right;
            deemph_active_out  <= deemph_reg;
            effects_active_out <= effects_reg;
            drv_high_power_out <= drv_high_power_in;
            drv_enable_out     <= ~all_sources_off & ~shutdown_reg &
                                  ~(auto_mode & short_detect_in);
            current_limit_out  <= limit_mode;
            swing_out          <= swing_in;
            short_flag_out     <= short_flag_next;
        end
    end

    // Output samples pass unchanged; the datapath applies vol_*_out downstream.
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            out_valid_out  <= 1'b0;
            out_sample_out <= '0;
        end else begin
            out_valid_out  <= sample_tick;
            if (sample_tick) out_sample_out <= buf_data;
        end
    end
endmodule : dac_volume_power_short_ctrl

// [hw/dac_ctrl_pkg.sv]
// Shared types and constants for the DAC volume, power and short-circuit control.
// Assumes a single 200 MHz system clock and a sample strobe from the audio path.
package dac_ctrl_pkg;
    localparam int VOL_W = 7;                      // 0.5 dB per code, 0..127
    localparam logic [6:0] VOL_MUTE = 7'h7f;       // -63.5 dB treated as muted floor
    localparam logic [6:0] VOL_ZERO = 7'h00;       // 0 dB
    localparam int SAMPLE_W = 16;
    localparam int BUF_DEPTH = 2;
    localparam logic [1:0] PWR_UP_STABLE = 2'h0;
    localparam logic [1:0] PWR_UPPING    = 2'h1;
    localparam logic [1:0] PWR_DOWNING   = 2'h2;
    localparam logic [1:0] PWR_DOWN_STABLE = 2'h3;
    localparam logic [1:0] SWING_MAX = 2'h3;
    localparam logic [1:0] SWING_RESET = 2'h0;

    typedef struct packed {
        logic [SAMPLE_W-1:0] left;
        logic [SAMPLE_W-1:0] right;
    } sample_pair_s;

    typedef enum logic [4:0] {
        ST_OFF     = 5'h01,
        ST_RAMP_UP = 5'h02,
        ST_RUN     = 5'h04,
        ST_FMUTE   = 5'h08,
        ST_RAMP_DN = 5'h10
    } pwr_state_e;
endpackage : dac_ctrl_pkg

// [hw/vol_stepper.sv]
// One channel of soft-stepped digital attenuation.
// Assumes sample_tick_in is a one-cycle pulse per accepted input sample.
`timescale 1ns/100ps
module vol_stepper (
    input  wire logic       clk_sys_in,
    input  wire logic       arst_n_in,
    input  wire logic       sample_tick_in,
    input  wire logic       half_rate_in,
    input  wire logic       bypass_in,
    input  wire logic [6:0] target_in,
    output logic [6:0]      applied_out,
    output logic            done_out
);
    logic [6:0] applied_reg;
    logic       odd_reg;
    logic       step_ok;
    logic [6:0] applied_next;

    assign step_ok = sample_tick_in & (~half_rate_in | odd_reg);
    assign applied_next = bypass_in ? target_in :
                          (applied_reg < target_in) ? applied_reg + 7'h01 :
                          (applied_reg > target_in) ? applied_reg - 7'h01 : applied_reg;

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            applied_reg <= dac_ctrl_pkg::VOL_MUTE;
            odd_reg     <= 1'b0;
        end else if (sample_tick_in) begin
            odd_reg <= ~odd_reg;
            if (step_ok || bypass_in) begin
                applied_reg <= applied_next;
            end
        end
    end

    assign applied_out = applied_reg;
    assign done_out    = bypass_in | (applied_reg == target_in);
endmodule : vol_stepper

// [hw/skid_buf2.sv]
// Two-entry buffer with valid/ready on both sides.
// Assumes the drain side may stall at any time.
`timescale 1ns/100ps
module skid_buf2 (
    input  wire logic                      clk_sys_in,
    input  wire logic                      arst_n_in,
    input  wire logic                      in_valid_in,
    output logic                           in_ready_out,
    input  wire dac_ctrl_pkg::sample_pair_s in_data_in,
    output logic                           out_valid_out,
    input  wire logic                      out_ready_in,
    output dac_ctrl_pkg::sample_pair_s     out_data_out
);
    dac_ctrl_pkg::sample_pair_s mem_reg [dac_ctrl_pkg::BUF_DEPTH];
    logic       wr_ptr_reg;
    logic       rd_ptr_reg;
    logic [1:0] count_reg;
    logic       push;
    logic       pop;

    assign in_ready_out  = (count_reg != 2'h2);
    assign out_valid_out = (count_reg != 2'h0);
    assign push = in_valid_in & in_ready_out;
    assign pop  = out_valid_out & out_ready_in;
    assign out_data_out = mem_reg[rd_ptr_reg];

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end else begin
            if (push) wr_ptr_reg <= ~wr_ptr_reg;
            if (pop) rd_ptr_reg <= ~rd_ptr_reg;
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (push) mem_reg[wr_ptr_reg] <= in_data_in;
    end
endmodule : skid_buf2

// [verification/dac_ctrl_monitor.sv]
// Concurrent checks on the ports of the DAC volume, power and short-circuit control.
// Assumes host inputs sit at zero while reset is held.
`timescale 1ns/100ps
module dac_ctrl_monitor (
    input wire logic       clk_sys_in,
    input wire logic       arst_n_in,
    input wire logic       out_valid_out,
    input wire logic       sample_ready_out,
    input wire logic       softstep_dis_in,
    input wire logic       dac_power_in,
    input wire logic       drv_high_power_in,
    input wire logic       drv_high_power_out,
    input wire logic       drv_enable_out,
    input wire logic       current_limit_out,
    input wire logic       short_detect_in,
    input wire logic       short_flag_out,
    input wire logic [1:0] swing_in,
    input wire logic [1:0] swing_out,
    input wire logic [1:0] short_mode_in,
    input wire logic [1:0] power_status_out,
    input wire logic [6:0] vol_left_out,
    input wire logic [6:0] vol_right_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!arst_n_in);
    a_swing_follow: assert property (1 |=> swing_out == $past(swing_in))
        else $error("swing output does not follow its request");
    a_drv_power_mode: assert property (
        1 |=> drv_high_power_out == $past(drv_high_power_in))
        else $error("driver power mode does not follow its request");
    a_protect_off: assert property (short_mode_in[0] |=>
        !short_flag_out && !current_limit_out)
        else $error("protection still active while disabled");
    a_limit_flag: assert property (short_mode_in == 2'h0 |=>
        current_limit_out && short_flag_out == $past(short_detect_in))
        else $error("current limit flag does not track the short");
    a_shutdown_trip: assert property (short_mode_in == 2'h2 && short_detect_in |=>
        short_flag_out && !drv_enable_out)
        else $error("auto shutdown did not trip");
    // Applied code moves on the tick edge and shows one edge later, so look back two
    a_vol_one_step: assert property (
        !softstep_dis_in && !$past(softstep_dis_in) && !$past(softstep_dis_in, 2) &&
        $changed(vol_left_out) |-> $past(out_valid_out) &&
        (vol_left_out - $past(vol_left_out) == 7'h01 ||
         $past(vol_left_out) - vol_left_out == 7'h01))
        else $error("volume moved by more than one step or off a sample");
    a_pwr_up_start: assert property (power_status_out == 2'h3 && dac_power_in |=>
        power_status_out == 2'h1)
        else $error("power up not reported");
    a_pwr_down_start: assert property (power_status_out == 2'h0 && !dac_power_in |=>
        power_status_out == 2'h2)
        else $error("power down not reported");
    a_down_muted: assert property (power_status_out == 2'h3 |->
        vol_left_out == 7'h7f && vol_right_out == 7'h7f)
        else $error("powered down while not muted");
    c_powered: cover property (power_status_out == 2'h0);
    c_tripped: cover property (short_mode_in == 2'h2 && short_detect_in);
    c_buf_full: cover property (!sample_ready_out);
endmodule : dac_ctrl_monitor
bind dac_volume_power_short_ctrl dac_ctrl_monitor u_dac_ctrl_monitor (
    .clk_sys_in, .arst_n_in, .out_valid_out, .sample_ready_out, .softstep_dis_in,
    .dac_power_in, .drv_high_power_in, .drv_high_power_out, .drv_enable_out,
    .current_limit_out, .short_detect_in, .short_flag_out, .swing_in, .swing_out,
    .short_mode_in, .power_status_out, .vol_left_out, .vol_right_out);

// [verification/sample_sink_model.sv]
// Receiving end of the sample stream; keeps every word handed to it.
// Assumes each out_valid pulse carries one sample pair.
`timescale 1ns/100ps
module sample_sink_model (
    input  wire logic                       clk_sys_in,
    input  wire logic                       stall_in,
    input  wire logic                       out_valid_in,
    input  wire dac_ctrl_pkg::sample_pair_s out_sample_in,
    output logic                            out_ready_out
);
    dac_ctrl_pkg::sample_pair_s got[$];
    // Ready is a level; a stall must never cost a word already in the buffer
    assign out_ready_out = !stall_in;
    always @(posedge clk_sys_in) begin
        if (out_valid_in) got.push_back(out_sample_in);
    end
endmodule : sample_sink_model

// [verification/dac_volume_power_short_ctrl_tb.sv]
// Self-checking bench of the DAC volume, power and short-circuit control.
// Assumes the sink model on the output stream and the bound checker.
`timescale 1ns/100ps
module dac_volume_power_short_ctrl_tb;
    logic clk_sys_in, arst_n_in, sample_valid_in, master_sel_in, mute_left_in, mute_right_in;
    logic half_rate_in, softstep_dis_in, deemph_en_in, effects_en_in, dac_power_in, stall;
    logic mixer_power_in, keyclick_power_in, drv_high_power_in, short_detect_in;
    logic [1:0] swing_in, short_mode_in, power_status_out, swing_out;
    logic [6:0] vol_left_in, vol_right_in, vol_master_in, vol_left_out, vol_right_out;
    logic out_ready_in, sample_ready_out, out_valid_out, done_left_out, done_right_out;
    logic deemph_active_out, effects_active_out, drv_high_power_out, drv_enable_out;
    logic current_limit_out, short_flag_out;
    dac_ctrl_pkg::sample_pair_s sample_in, out_sample_out;
    // Row: swing, high power, mode, detect -> swing, high power, flag, limit
    logic [10:0] rows [4] = '{11'h73f, 11'h411, 11'h36c, 11'h0e0};
    int error_cnt = 0;
    int cmp_count = 0;
    int i, n0;
    logic [4:0] row_seen;
    dac_volume_power_short_ctrl u_dac_volume_power_short_ctrl (.clk_sys_in, .arst_n_in,
        .sample_valid_in, .sample_ready_out, .sample_in, .out_valid_out, .out_ready_in,
        .out_sample_out, .vol_left_in, .vol_right_in, .vol_master_in, .master_sel_in,
        .mute_left_in, .mute_right_in, .half_rate_in, .softstep_dis_in, .deemph_en_in,
        .effects_en_in, .dac_power_in, .mixer_power_in, .keyclick_power_in,
        .drv_high_power_in, .swing_in, .short_mode_in, .short_detect_in, .vol_left_out,
        .vol_right_out, .done_left_out, .done_right_out, .power_status_out,
        .deemph_active_out, .effects_active_out, .drv_high_power_out, .drv_enable_out,
        .current_limit_out, .swing_out, .short_flag_out);
    sample_sink_model u_sample_sink_model (.clk_sys_in, .stall_in(stall),
        .out_valid_in(out_valid_out), .out_sample_in(out_sample_out),
        .out_ready_out(out_ready_in));
    assign row_seen = {swing_out, drv_high_power_out, short_flag_out, current_limit_out};
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            error_cnt++;
        end
    endtask : chk
    task automatic cyc(int n);
        repeat (n) @(negedge clk_sys_in);
    endtask : cyc
    // Holds the offer until the edge that takes it, then idles so ticks land apart
    task automatic send(logic [31:0] d, int gap);
        int k;
        sample_in = d;
        sample_valid_in = 1'b1;
        for (k = 0; k < 50 && sample_ready_out !== 1'b1; k++) cyc(1);
        cyc(1);
        sample_valid_in = 1'b0;
        cyc(gap);
    endtask : send
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results
    // Clock never stops, but power-down sequencing completes only as samples tick
    initial begin
        clk_sys_in = 1'b0;
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        #400000;
        error_cnt++;
        results();
    end
    initial begin
        {sample_valid_in, master_sel_in, mute_left_in, mute_right_in, half_rate_in} = '0;
        {softstep_dis_in, deemph_en_in, effects_en_in, dac_power_in, stall, arst_n_in} = '0;
        {mixer_power_in, keyclick_power_in, drv_high_power_in, short_detect_in} = '0;
        {swing_in, short_mode_in, vol_left_in, vol_right_in, vol_master_in, sample_in} = '0;
        cyc(4);
        arst_n_in = 1'b1;
        chk("vol_rst", 14'h3fff, {vol_left_out, vol_right_out});
        chk("status_rst", 2'h3, power_status_out);
        chk("drv_rst", 1'b0, drv_high_power_out);
        $display("test reset done");
        {mixer_power_in, keyclick_power_in} = 2'h3;
        foreach (rows[k]) begin
            {swing_in, drv_high_power_in, short_mode_in, short_detect_in} = rows[k][10:5];
            cyc(2);
            chk("row", rows[k][4:0], row_seen);
        end
        {short_mode_in, short_detect_in} = 3'h0;
        $display("test rows done");
        vol_left_in = 7'h64;
        vol_right_in = 7'h70;
        dac_power_in = 1'b1;
        cyc(1);
        chk("status_up", 2'h1, power_status_out);
        for (i = 0; i < 3; i++) send(i, 3);
        chk("ramp", 14'h3e7c, {vol_left_out, vol_right_out});
        half_rate_in = 1'b1;
        for (i = 0; i < 4; i++) send(i, 3);
        chk("half_rate", 7'h7a, vol_left_out);
        half_rate_in = 1'b0;
        for (i = 0; i < 60 && power_status_out !== 2'h0; i++) send(i, 3);
        chk("vol_up", 14'h3270, {vol_left_out, vol_right_out});
        chk("done_up", 2'h3, {done_left_out, done_right_out});
        $display("test power_up done");
        softstep_dis_in = 1'b1;
        vol_left_in = 7'h00;
        send(32'h0, 3);
        chk("bypass", 7'h00, vol_left_out);
        chk("bypass_done", 1'b1, done_left_out);
        master_sel_in = 1'b1;
        vol_master_in = 7'h20;
        send(32'h0, 3);
        chk("master", 14'h1020, {vol_left_out, vol_right_out});
        mute_right_in = 1'b1;
        send(32'h0, 3);
        chk("mute_r", 14'h107f, {vol_left_out, vol_right_out});
        {master_sel_in, mute_right_in} = 2'h0;
        send(32'h0, 3);
        softstep_dis_in = 1'b0;
        $display("test bypass done");
        {deemph_en_in, effects_en_in} = 2'h3;
        cyc(1);
        chk("filt_wait", 2'h0, {deemph_active_out, effects_active_out});
        for (i = 0; i < 200 && effects_active_out !== 1'b1; i++) send(i, 6);
        chk("filt_mute", 14'h3fff, {vol_left_out, vol_right_out});
        chk("filt_on", 2'h3, {deemph_active_out, effects_active_out});
        for (i = 0; i < 200 && power_status_out !== 2'h0; i++) send(i, 4);
        chk("filt_back", 14'h0070, {vol_left_out, vol_right_out});
        $display("test filter done");
        stall = 1'b1;
        n0 = u_sample_sink_model.got.size();
        send(32'h1111_2222, 1);
        send(32'h3333_4444, 1);
        sample_valid_in = 1'b1;
        cyc(2);
        chk("buf_full", 1'b0, sample_ready_out);
        sample_valid_in = 1'b0;
        stall = 1'b0;
        cyc(8);
        chk("buf_cnt", n0 + 2, u_sample_sink_model.got.size());
        chk("buf_w0", 32'h1111_2222, u_sample_sink_model.got[n0]);
        chk("buf_w1", 32'h3333_4444, u_sample_sink_model.got[n0+1]);
        $display("test buffer done");
        dac_power_in = 1'b0;
        cyc(1);
        chk("status_dn", 2'h2, power_status_out);
        for (i = 0; i < 200 && power_status_out !== 2'h3; i++) send(i, 3);
        chk("vol_dn", 14'h3fff, {vol_left_out, vol_right_out});
        $display("test power_down done");
        {short_mode_in, short_detect_in} = 3'h5;
        cyc(1);
        short_detect_in = 1'b0;
        cyc(2);
        chk("trip", 2'h1, {drv_enable_out, short_flag_out});
        mixer_power_in = 1'b0;
        cyc(2);
        chk("trip_hold", 1'b1, short_flag_out);
        keyclick_power_in = 1'b0;
        cyc(2);
        chk("trip_clr", 1'b0, short_flag_out);
        $display("test shutdown done");
        results();
    end
endmodule : dac_volume_power_short_ctrl_tb
